// file: pkg/hcl_cfg.svh
// constants for the hub configuration loader
`ifndef HCL_CFG_SVH
`define HCL_CFG_SVH

// -------------------------------------------------------------
// apb register map
// -------------------------------------------------------------
`define HCL_REG_CTRL       8'h00
`define HCL_REG_STAT       8'h04
`define HCL_REG_IMG0       8'h08
`define HCL_REG_IMG1       8'h0c
`define HCL_REG_IMG2       8'h10
`define HCL_REG_IMG3       8'h14
`define HCL_REG_PON        8'h18
`define HCL_CTRL_EE_BIT    0
`define HCL_CTRL_SELF_BIT  1
`define HCL_CTRL_LOAD_BIT  2
`define HCL_CTRL_RST       2'b11

// -------------------------------------------------------------
// serial memory and image layout
// -------------------------------------------------------------
`define HCL_DEV_ADDR       7'b1010000
`define HCL_IMG_LEN        16
`define HCL_IMG_LAST       4'hf
`define HCL_IMG_START      8'h00
`define HCL_OFF_OPT1       4'h6
`define HCL_OFF_OPT2       4'h7
`define HCL_OFF_NONREM     4'h8
`define HCL_OFF_DIS_SELF   4'h9
`define HCL_OFF_DIS_BUS    4'ha
`define HCL_OFF_PWR_SELF   4'hb
`define HCL_OFF_PWR_BUS    4'hc
`define HCL_OFF_CUR_SELF   4'hd
`define HCL_OFF_CUR_BUS    4'he
`define HCL_OFF_PON        4'hf
`define HCL_OPT2_COMPOUND  3

// -------------------------------------------------------------
// image defaults
// -------------------------------------------------------------
`define HCL_DEF_OPT1_SELF  8'h98
`define HCL_DEF_OPT1_BUS   8'h1c
`define HCL_DEF_OPT2       8'h90
`define HCL_DEF_MASK       8'h00
`define HCL_DEF_PWR_SELF   8'h01
`define HCL_DEF_PWR_BUS    8'h64
`define HCL_DEF_CUR_SELF   8'h01
`define HCL_DEF_CUR_BUS    8'h64
`define HCL_DEF_PON        8'h32

// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define HCL_LINK_CLK_NS    160
`define HCL_SCL_BIT_NS     10000
`define HCL_QTR_CYC        ((`HCL_SCL_BIT_NS / 4 + `HCL_LINK_CLK_NS - 1) / `HCL_LINK_CLK_NS)

`endif

// file: pkg/hcl_pkg.sv
// types shared by the hub configuration loader
package hcl_pkg;
	typedef enum logic [2:0] {
		HCL_S_BOOT = 3'b001,
		HCL_S_LOAD = 3'b010,
		HCL_S_RUN  = 3'b100
	} hcl_sys_e;

	typedef enum logic [4:0] {
		HCL_L_IDLE  = 5'b00001,
		HCL_L_START = 5'b00010,
		HCL_L_WR    = 5'b00100,
		HCL_L_RD    = 5'b01000,
		HCL_L_STOP  = 5'b10000
	} hcl_link_e;

	typedef logic [7:0] hcl_byte_t;
endpackage : hcl_pkg

// file: rtl/hcl_sync2.sv
// two-flop level synchroniser
`timescale 1ns/10ps
module hcl_sync2 #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk_i,
	// level in and out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o  <= meta;
	end
endmodule : hcl_sync2

// file: rtl/hcl_evt_sync.sv
// toggle-to-pulse event crossing
`timescale 1ns/10ps
module hcl_evt_sync (
	// destination clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// toggle in, one-cycle pulse out
	input  wire logic tgl_i,
	output logic      pulse_o
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= tgl_i;
			sync <= meta;
			prev <= sync;
		end
	end

	assign pulse_o = sync ^ prev;
endmodule : hcl_evt_sync

// file: rtl/hcl_loader.sv
// hub configuration loader: apb registers and two-wire memory reader
// How it works
// - fetch image first, attach afterwards
// - standard mode, 100kbit/s, 7-bit addressing
// - sole master: clock, direction, start, stop
// - one memory, basic feature set only
// - target address is 1010000
// - never send 10-bit address sequences
// - lines released while chip reset held
// - id fields from pairs, high byte upper
// - option byte one at 6, defaults
// - option byte two at 7, default 90
// - attachment mask used only if compound
// - port disable masks at 9 and A
// - max power in 2mA, bus at C
// - controller current at D and E
// - power-on time at F, reported
// - power-on time counts 2ms steps
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "hcl_cfg.svh"
module hcl_loader import hcl_pkg::*; #(
	parameter logic [15:0] VENDOR_DEF  = 16'h5a01, // arbitrary value
	parameter logic [15:0] PRODUCT_DEF = 16'h5a02, // arbitrary value
	parameter logic [15:0] RELEASE_DEF = 16'h0101, // arbitrary value
	parameter int          QTR         = `HCL_QTR_CYC
) (
	// clocks and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        link_clk_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	// two-wire configuration bus
	input  wire logic        config_bus_clock_pin_i,
	output logic             config_bus_clock_pin_o,
	output logic             config_bus_clock_pin_oe_o,
	input  wire logic        config_bus_data_pin_i,
	output logic             config_bus_data_pin_o,
	output logic             config_bus_data_pin_oe_o,
	// configuration towards the hub core
	output logic             attach_o,
	output logic [15:0]      vendor_code_o,
	output logic [15:0]      product_code_o,
	output logic [15:0]      release_code_o,
	output logic [7:0]       hub_opt1_o,
	output logic [7:0]       hub_opt2_o,
	output logic [7:0]       nonrem_ports_o,
	output logic [7:0]       port_disable_o,
	output logic [7:0]       max_power_o,
	output logic [7:0]       hc_current_o,
	output logic [7:0]       power_on_time_o
);
	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	hcl_sys_e   sys_state, next_sys_state;
	hcl_byte_t  cfg [`HCL_IMG_LEN];
	hcl_byte_t  next_cfg [`HCL_IMG_LEN];
	hcl_byte_t  img [`HCL_IMG_LEN];
	logic       ee_sel, next_ee_sel;
	logic       self_pwr, next_self_pwr;
	logic       start_tgl, next_start_tgl;
	logic       load_err, next_load_err;
	logic       from_ee, next_from_ee;
	logic       done_pls;
	logic       apb_setup, apb_wr, reload;
	logic       next_pready, next_pslverr;
	logic [31:0] next_prdata;

	hcl_link_e  lstate, next_lstate;
	logic       rst_link, start_pls, scl_s, sda_s, tick, img_we;
	logic [7:0] qcnt, next_qcnt;
	logic [1:0] qph, next_qph;
	logic [3:0] bitn, next_bitn;
	logic [1:0] step, next_step;
	logic [3:0] rdidx, next_rdidx;
	hcl_byte_t  shreg, next_shreg;
	logic       lerr, next_lerr;
	logic       done_tgl, next_done_tgl;
	logic       sda_oe, next_sda_oe;
	logic       scl_oe, next_scl_oe;

	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	function automatic hcl_byte_t def_byte(input logic [3:0] idx, input logic self);
		unique case (idx)
			4'h0: def_byte = VENDOR_DEF[7:0];
			4'h1: def_byte = VENDOR_DEF[15:8];
			4'h2: def_byte = PRODUCT_DEF[7:0];
			4'h3: def_byte = PRODUCT_DEF[15:8];
			4'h4: def_byte = RELEASE_DEF[7:0];
			4'h5: def_byte = RELEASE_DEF[15:8];
			`HCL_OFF_OPT1: def_byte = self ? `HCL_DEF_OPT1_SELF : `HCL_DEF_OPT1_BUS;
			`HCL_OFF_OPT2: def_byte = `HCL_DEF_OPT2;
			`HCL_OFF_PWR_SELF: def_byte = `HCL_DEF_PWR_SELF;
			`HCL_OFF_PWR_BUS: def_byte = `HCL_DEF_PWR_BUS;
			`HCL_OFF_CUR_SELF: def_byte = `HCL_DEF_CUR_SELF;
			`HCL_OFF_CUR_BUS: def_byte = `HCL_DEF_CUR_BUS;
			`HCL_OFF_PON: def_byte = `HCL_DEF_PON;
			default: def_byte = `HCL_DEF_MASK;
		endcase
	endfunction : def_byte

	function automatic logic [31:0] img_word(input int base);
		img_word = {cfg[base+3], cfg[base+2], cfg[base+1], cfg[base]};
	endfunction : img_word

	// -------------------------------------------------------------
	// crossings
	// -------------------------------------------------------------
	// link reset follows chip reset a couple of link edges late
	hcl_sync2 #(.W(1)) u_rst_sync (
		.clk_i (link_clk_i),
		.d_i   (rst_i),
		.q_o   (rst_link)
	);

	hcl_sync2 #(.W(2)) u_pin_sync (
		.clk_i (link_clk_i),
		.d_i   ({config_bus_clock_pin_i, config_bus_data_pin_i}),
		.q_o   ({scl_s, sda_s})
	);

	hcl_evt_sync u_start_sync (
		.clk_i   (link_clk_i),
		.rst_i   (rst_link),
		.tgl_i   (start_tgl),
		.pulse_o (start_pls)
	);

	hcl_evt_sync u_done_sync (
		.clk_i   (sys_clk_i),
		.rst_i   (rst_i),
		.tgl_i   (done_tgl),
		.pulse_o (done_pls)
	);

	// open drain: only the enables move
	assign config_bus_clock_pin_o    = 1'b0;
	assign config_bus_data_pin_o     = 1'b0;
	assign config_bus_clock_pin_oe_o = scl_oe;
	assign config_bus_data_pin_oe_o  = sda_oe;

	// -------------------------------------------------------------
	// system side: apb, load sequencing, outputs
	// -------------------------------------------------------------
	assign apb_setup = psel_i && !penable_i;
	assign apb_wr    = psel_i && penable_i && pready_o && pwrite_i;

	always_comb begin
		next_sys_state = sys_state;
		next_ee_sel    = ee_sel;
		next_self_pwr  = self_pwr;
		next_start_tgl = start_tgl;
		next_load_err  = load_err;
		next_from_ee   = from_ee;
		next_cfg       = cfg;
		reload         = 1'b0;
		if (apb_wr && paddr_i == `HCL_REG_CTRL) begin
			next_ee_sel   = pwdata_i[`HCL_CTRL_EE_BIT];
			next_self_pwr = pwdata_i[`HCL_CTRL_SELF_BIT];
			reload        = pwdata_i[`HCL_CTRL_LOAD_BIT];
		end
		unique case (sys_state)
			HCL_S_BOOT: begin
				if (ee_sel) begin
					next_start_tgl = !start_tgl;
					next_sys_state = HCL_S_LOAD;
					next_from_ee   = 1'b1;
				end else begin
					for (int i = 0; i < `HCL_IMG_LEN; i++) begin
						next_cfg[i] = def_byte(4'(i), self_pwr);
					end
					next_from_ee   = 1'b0;
					next_load_err  = 1'b0;
					next_sys_state = HCL_S_RUN;
				end
			end
			HCL_S_LOAD: begin
				// img and lerr are frozen while the link sits idle
				if (done_pls) begin
					for (int i = 0; i < `HCL_IMG_LEN; i++) begin
						next_cfg[i] = lerr ? def_byte(4'(i), self_pwr) : img[i];
					end
					next_load_err  = lerr;
					next_sys_state = HCL_S_RUN;
				end
			end
			HCL_S_RUN: begin
				if (reload) begin
					next_sys_state = HCL_S_BOOT;
				end
			end
		endcase
	end

	always_comb begin
		next_pready  = apb_setup;
		next_pslverr = 1'b0;
		next_prdata  = 32'h0000_0000;
		if (apb_setup) begin
			unique case (paddr_i)
				`HCL_REG_CTRL: next_prdata = {30'h0, self_pwr, ee_sel};
				`HCL_REG_STAT: next_prdata = {28'h000_0000, from_ee, load_err,
					attach_o, sys_state == HCL_S_LOAD};
				`HCL_REG_IMG0: next_prdata = img_word(0);
				`HCL_REG_IMG1: next_prdata = img_word(4);
				`HCL_REG_IMG2: next_prdata = img_word(8);
				`HCL_REG_IMG3: next_prdata = img_word(12);
				`HCL_REG_PON:  next_prdata = {23'h0, cfg[`HCL_OFF_PON], 1'b0};
				default:       next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sys_state <= HCL_S_BOOT;
			{ee_sel, self_pwr} <= `HCL_CTRL_RST;
			start_tgl <= 1'b0;
			load_err  <= 1'b0;
			from_ee   <= 1'b0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			for (int i = 0; i < `HCL_IMG_LEN; i++) begin
				cfg[i] <= 8'h00;
			end
		end else begin
			sys_state <= next_sys_state;
			ee_sel    <= next_ee_sel;
			self_pwr  <= next_self_pwr;
			start_tgl <= next_start_tgl;
			load_err  <= next_load_err;
			from_ee   <= next_from_ee;
			pready_o  <= next_pready;
			pslverr_o <= next_pslverr;
			prdata_o  <= next_prdata;
			cfg       <= next_cfg;
		end
	end

	// outputs trail the image by one edge, attach included
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			attach_o        <= 1'b0;
			vendor_code_o   <= 16'h0000;
			product_code_o  <= 16'h0000;
			release_code_o  <= 16'h0000;
			hub_opt1_o      <= 8'h00;
			hub_opt2_o      <= 8'h00;
			nonrem_ports_o  <= 8'h00;
			port_disable_o  <= 8'h00;
			max_power_o     <= 8'h00;
			hc_current_o    <= 8'h00;
			power_on_time_o <= 8'h00;
		end else begin
			attach_o        <= sys_state == HCL_S_RUN;
			vendor_code_o   <= {cfg[1], cfg[0]};
			product_code_o  <= {cfg[3], cfg[2]};
			release_code_o  <= {cfg[5], cfg[4]};
			hub_opt1_o      <= cfg[`HCL_OFF_OPT1];
			hub_opt2_o      <= cfg[`HCL_OFF_OPT2];
			nonrem_ports_o  <= cfg[`HCL_OFF_OPT2][`HCL_OPT2_COMPOUND] ?
				cfg[`HCL_OFF_NONREM] : `HCL_DEF_MASK;
			port_disable_o  <= self_pwr ? cfg[`HCL_OFF_DIS_SELF] :
				cfg[`HCL_OFF_DIS_BUS];
			max_power_o     <= self_pwr ? cfg[`HCL_OFF_PWR_SELF] :
				cfg[`HCL_OFF_PWR_BUS];
			hc_current_o    <= self_pwr ? cfg[`HCL_OFF_CUR_SELF] :
				cfg[`HCL_OFF_CUR_BUS];
			power_on_time_o <= cfg[`HCL_OFF_PON];
		end
	end

	// -------------------------------------------------------------
	// link side: two-wire master, quarter-bit sequencer
	// -------------------------------------------------------------
	// a quarter ends only once the clock line is seen high in q2,
	// so a slow target can stretch the low phase
	assign tick = (qcnt == 8'(QTR - 1)) && !(qph == 2'd2 && !scl_s);

	always_comb begin
		next_lstate   = lstate;
		next_qcnt     = qcnt;
		next_qph      = qph;
		next_bitn     = bitn;
		next_step     = step;
		next_rdidx    = rdidx;
		next_shreg    = shreg;
		next_lerr     = lerr;
		next_done_tgl = done_tgl;
		next_sda_oe   = sda_oe;
		next_scl_oe   = scl_oe;
		img_we        = 1'b0;
		if (lstate == HCL_L_IDLE) begin
			next_qcnt = 8'h00;
			next_qph  = 2'd0;
			if (start_pls) begin
				next_lstate = HCL_L_START;
				next_step   = 2'd0;
				next_lerr   = 1'b0;
			end
		end else begin
			next_qcnt = tick ? 8'h00 :
				(qcnt == 8'(QTR - 1) ? qcnt : qcnt + 8'h01);
			if (tick) begin
				next_qph = qph + 2'd1;
				unique case (lstate)
					HCL_L_START: begin
						unique case (qph)
							2'd0: next_sda_oe = 1'b0;
							2'd1: next_scl_oe = 1'b0;
							2'd2: next_sda_oe = 1'b1;
							2'd3: begin
								next_scl_oe = 1'b1;
								next_lstate = HCL_L_WR;
								next_bitn   = 4'd0;
								// only 7-bit address bytes ever leave here
								next_shreg  = {`HCL_DEV_ADDR, step != 2'd0};
							end
						endcase
					end
					HCL_L_WR, HCL_L_RD: begin
						unique case (qph)
							2'd0: next_sda_oe = (lstate == HCL_L_WR) ?
								(bitn < 4'd8 && !shreg[7]) :
								(bitn == 4'd8 && rdidx != `HCL_IMG_LAST);
							2'd1: next_scl_oe = 1'b0;
							2'd2: begin
								if (bitn < 4'd8 || lstate == HCL_L_WR) begin
									next_shreg = {shreg[6:0], sda_s};
								end
							end
							2'd3: begin
								next_scl_oe = 1'b1;
								next_bitn   = bitn + 4'd1;
								if (bitn == 4'd8) begin
									next_bitn = 4'd0;
									if (lstate == HCL_L_RD) begin
										img_we = 1'b1;
										if (rdidx == `HCL_IMG_LAST) begin
											next_lstate = HCL_L_STOP;
										end else begin
											next_rdidx = rdidx + 4'd1;
										end
									end else if (shreg[0]) begin
										// no target answered: give up, keep defaults
										next_lerr   = 1'b1;
										next_lstate = HCL_L_STOP;
									end else begin
										unique case (step)
											2'd0: begin
												next_step  = 2'd1;
												next_shreg = `HCL_IMG_START;
											end
											2'd1: begin
												next_step   = 2'd2;
												next_lstate = HCL_L_START;
											end
											default: begin
												next_lstate = HCL_L_RD;
												next_rdidx  = 4'd0;
											end
										endcase
									end
								end
							end
						endcase
					end
					HCL_L_STOP: begin
						unique case (qph)
							2'd0: next_sda_oe = 1'b1;
							2'd1: next_scl_oe = 1'b0;
							2'd2: next_sda_oe = 1'b0;
							2'd3: begin
								next_lstate   = HCL_L_IDLE;
								next_done_tgl = !done_tgl;
							end
						endcase
					end
					default: next_lstate = HCL_L_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (rst_link) begin
			lstate   <= HCL_L_IDLE;
			qcnt     <= 8'h00;
			qph      <= 2'd0;
			bitn     <= 4'd0;
			step     <= 2'd0;
			rdidx    <= 4'd0;
			shreg    <= 8'h00;
			lerr     <= 1'b0;
			done_tgl <= 1'b0;
			sda_oe   <= 1'b0;
			scl_oe   <= 1'b0;
		end else begin
			lstate   <= next_lstate;
			qcnt     <= next_qcnt;
			qph      <= next_qph;
			bitn     <= next_bitn;
			step     <= next_step;
			rdidx    <= next_rdidx;
			shreg    <= next_shreg;
			lerr     <= next_lerr;
			done_tgl <= next_done_tgl;
			sda_oe   <= next_sda_oe;
			scl_oe   <= next_scl_oe;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (img_we) begin
			img[rdidx] <= shreg;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	logic [7:0] hi_cnt;

	always_ff @(posedge link_clk_i) begin
		if (rst_link || scl_oe) begin
			hi_cnt <= 8'h00;
		end else if (hi_cnt != 8'hff) begin
			hi_cnt <= hi_cnt + 8'h01;
		end
	end

	property p_rst_release;
		@(posedge link_clk_i) rst_link |=> !sda_oe && !scl_oe;
	endproperty
	a_rst_release: assert property (p_rst_release) else $error("bus driven in reset");

	property p_scl_high;
		@(posedge link_clk_i) disable iff (rst_link)
		$rose(scl_oe) |-> hi_cnt >= 8'(2 * QTR);
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("clock high too short");

	property p_start_only;
		@(posedge link_clk_i) disable iff (rst_link)
		$rose(sda_oe) && !scl_oe |-> lstate == HCL_L_START && qph == 2'd3;
	endproperty
	a_start_only: assert property (p_start_only) else $error("stray start");

	property p_stop_only;
		@(posedge link_clk_i) disable iff (rst_link)
		$fell(sda_oe) && !scl_oe |-> lstate == HCL_L_STOP || lstate == HCL_L_IDLE;
	endproperty
	a_stop_only: assert property (p_stop_only) else $error("stray stop");

	property p_addr_byte;
		@(posedge link_clk_i) disable iff (rst_link)
		$rose(lstate == HCL_L_WR) && step != 2'd1 |->
			shreg == {`HCL_DEV_ADDR, step == 2'd2} ##1 shreg[7:3] != 5'b11110;
	endproperty
	a_addr_byte: assert property (p_addr_byte) else $error("wrong address");

	property p_read_ack;
		@(posedge link_clk_i) disable iff (rst_link)
		lstate == HCL_L_RD && bitn == 4'd8 && qph == 2'd2 |->
			sda_oe == (rdidx != `HCL_IMG_LAST);
	endproperty
	a_read_ack: assert property (p_read_ack) else $error("bad acknowledge");

	property p_last_stop;
		@(posedge link_clk_i) disable iff (rst_link)
		img_we && rdidx == `HCL_IMG_LAST |=> lstate == HCL_L_STOP && qph == 2'd0;
	endproperty
	a_last_stop: assert property (p_last_stop) else $error("no stop after last");

	property p_no_attach_load;
		@(posedge sys_clk_i) disable iff (rst_i)
		sys_state == HCL_S_LOAD |=> !attach_o;
	endproperty
	a_no_attach_load: assert property (p_no_attach_load) else $error("early attach");

	property p_ids;
		@(posedge sys_clk_i) disable iff (rst_i)
		attach_o && $past(attach_o) |-> vendor_code_o == {cfg[1], cfg[0]} &&
			release_code_o == {cfg[5], cfg[4]};
	endproperty
	a_ids: assert property (p_ids) else $error("id byte order");

	property p_nonrem;
		@(posedge sys_clk_i) disable iff (rst_i)
		attach_o |-> nonrem_ports_o == ($past(cfg[`HCL_OFF_OPT2][`HCL_OPT2_COMPOUND]) ?
			$past(cfg[`HCL_OFF_NONREM]) : 8'h00);
	endproperty
	a_nonrem: assert property (p_nonrem) else $error("mask without compound");

	property p_port_dis;
		@(posedge sys_clk_i) disable iff (rst_i)
		attach_o |-> port_disable_o == ($past(self_pwr) ?
			$past(cfg[`HCL_OFF_DIS_SELF]) : $past(cfg[`HCL_OFF_DIS_BUS]));
	endproperty
	a_port_dis: assert property (p_port_dis) else $error("wrong disable mask");

	c_load_ok: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		done_pls && !lerr ##2 attach_o);
	c_load_nack: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		done_pls && lerr);
	c_reload: cover property (@(posedge sys_clk_i) disable iff (rst_i)
		sys_state == HCL_S_RUN && reload);
endmodule : hcl_loader

// file: test/hcl_mem_model.sv
// two-wire serial memory model for the configuration loader
`timescale 1ns/10ps
module hcl_mem_model (
	// bus line levels
	input  wire logic scl_i,
	input  wire logic sda_i,
	// line pull-downs
	output logic      scl_oe_o,
	output logic      sda_oe_o,
	// commanded misbehaviour
	input  wire logic nack_i,
	input  wire logic slow_i
);
	logic [7:0] img [16];
	logic [7:0] sh;
	logic [7:0] adr;
	logic [3:0] ptr;
	logic       ack = 0;
	int         bc = 0;
	int         md = 0;
	int         starts = 0;

	// ------------------------------------------
	// framing and byte engine
	// ------------------------------------------
	initial begin
		scl_oe_o = 0;
		sda_oe_o = 0;
	end
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		md = 1;
		bc = 0;
		starts++;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) md = 0;
	always @(posedge scl_i) begin
		if (bc < 8) sh = {sh[6:0], sda_i};
		else if (md == 3 && sda_i) md = 0;
		if (bc == 7) begin
			ack = md == 2;
			if (md == 1) begin
				adr = sh;
				ack = sh[7:1] == 7'h50 && !nack_i;
				md = !ack ? 0 : sh[0] ? 3 : 2;
			end else if (md == 2) begin
				ptr = sh[3:0];
				md = 4;
			end else if (md == 3) ptr++;
		end
		bc = bc == 8 ? 0 : bc + 1;
	end
	// released data floats to the pull-up level
	always @(negedge scl_i) begin
		sda_oe_o = bc == 8 ? ack : md == 3 && !img[ptr][7 - bc];
		if (slow_i) begin
			scl_oe_o = 1;
			#2000 scl_oe_o = 0;
		end
	end
endmodule : hcl_mem_model

// file: test/hcl_loader_bench.sv
// self-checking bench for the configuration loader
`timescale 1ns/10ps
`include "hcl_cfg.svh"
module hcl_loader_bench import hcl_pkg::*;;
	localparam logic [15:0] VEN = 16'h1234; // arbitrary value
	logic        sys_clk = 0, link_clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	logic [7:0]  padr = '0;
	logic [31:0] pwd = '0, prd, rd, rows [8][3];
	logic        prdy, perr, er, d_scl, d_sda, d_scl_oe, d_sda_oe, m_scl_oe, m_sda_oe;
	logic        nack = 0, slow = 0, attach;
	logic [15:0] vc, pc, rc;
	logic [7:0]  o1, o2, nr, pd, mp, hc, pt, img [16];
	int          n_errors = 0, n_checks = 0, s0;
	wire         scl = (!d_scl_oe || d_scl) && !m_scl_oe;
	wire         sda = (!d_sda_oe || d_sda) && !m_sda_oe;

	always #25 sys_clk = !sys_clk;
	initial #13 forever #80 link_clk = !link_clk;

	hcl_loader #(.VENDOR_DEF(VEN), .QTR(2)) dut (
		.sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr),
		.pwdata_i(pwd), .pready_o(prdy), .prdata_o(prd), .pslverr_o(perr),
		.config_bus_clock_pin_i(scl), .config_bus_clock_pin_o(d_scl),
		.config_bus_clock_pin_oe_o(d_scl_oe), .config_bus_data_pin_i(sda),
		.config_bus_data_pin_o(d_sda), .config_bus_data_pin_oe_o(d_sda_oe),
		.attach_o(attach), .vendor_code_o(vc), .product_code_o(pc),
		.release_code_o(rc), .hub_opt1_o(o1), .hub_opt2_o(o2),
		.nonrem_ports_o(nr), .port_disable_o(pd), .max_power_o(mp),
		.hc_current_o(hc), .power_on_time_o(pt));
	hcl_mem_model mem (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe),
		.sda_oe_o(m_sda_oe), .nack_i(nack), .slow_i(slow));

	// ------------------------------------------
	// shared tasks
	// ------------------------------------------
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		psel <= 1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge sys_clk);
		pen <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (prdy === 1'b1) break;
		end
		if (i == 20) n_errors++;
		if (i == 20) finish_test;
		rd = prd;
		er = perr;
		psel <= 0;
		pen <= 0;
	endtask : apb
	task automatic wait_attach(input logic v);
		int i;
		for (i = 0; i < 20000; i++) begin
			@(posedge sys_clk);
			if (attach === v) break;
		end
		if (i == 20000) n_errors++;
		if (i == 20000) finish_test;
	endtask : wait_attach

	// ------------------------------------------
	// main sequence
	// ------------------------------------------
	initial begin
		for (int k = 0; k < 16; k++) img[k] = 8'(8'hc0 ^ 8'h11 * k);
		img[7] = 8'h98;
		for (int k = 0; k < 16; k++) mem.img[k] = img[k];
		repeat (6) @(posedge sys_clk);
		rst <= 0;
		repeat (3) @(posedge sys_clk);
		chk(attach, 0);
		wait_attach(1);
		chk({vc, pc}, {img[1], img[0], img[3], img[2]});
		chk({rc, o1, o2}, {img[5], img[4], img[6], img[7]});
		chk({nr, pd, mp, hc}, {img[8], img[9], img[11], img[13]});
		chk(pt, img[15]);
		chk(mem.starts, 2);
		chk(mem.adr, 8'ha1);
		rows[0] = '{`HCL_REG_CTRL, 32'h3, 0};
		rows[1] = '{`HCL_REG_STAT, 32'ha, 0};
		rows[2] = '{`HCL_REG_IMG0, {img[3], img[2], img[1], img[0]}, 0};
		rows[3] = '{`HCL_REG_IMG1, {img[7], img[6], img[5], img[4]}, 0};
		rows[4] = '{`HCL_REG_IMG2, {img[11], img[10], img[9], img[8]}, 0};
		rows[5] = '{`HCL_REG_IMG3, {img[15], img[14], img[13], img[12]}, 0};
		rows[6] = '{`HCL_REG_PON, {23'h0, img[15], 1'b0}, 0};
		rows[7] = '{8'h1c, 0, 1};
		for (int i = 0; i < 8; i++) begin
			apb(rows[i][0][7:0], 0, 0);
			chk(rd, rows[i][1]);
			chk(er, rows[i][2]);
		end
		// reprogram under reset, then bus setup with a stretching memory
		img[7] = 8'h90;
		rst <= 1;
		repeat (20) @(posedge sys_clk);
		mem.img[7] = img[7];
		rst <= 0;
		wait_attach(1);
		slow <= 1;
		apb(`HCL_REG_CTRL, 1, 32'h5);
		wait_attach(0);
		wait_attach(1);
		chk({nr, pd, mp, hc}, {8'h0, img[10], img[12], img[14]});
		chk(o2, img[7]);
		slow <= 0;
		// reset in mid-load, then refused address on the load after reset
		nack <= 1;
		apb(`HCL_REG_CTRL, 1, 32'h7);
		repeat (100) @(posedge sys_clk);
		rst <= 1;
		repeat (20) @(posedge sys_clk);
		chk({d_scl_oe, d_sda_oe, attach}, 0);
		rst <= 0;
		wait_attach(1);
		chk({o1, o2, mp, pt}, {8'h98, 8'h90, 8'h01, 8'h32});
		chk(vc, VEN);
		apb(`HCL_REG_STAT, 0, 0);
		chk(rd[2], 1);
		// memory not selected: defaults, no bus traffic
		s0 = mem.starts;
		apb(`HCL_REG_CTRL, 1, 32'h4);
		wait_attach(0);
		wait_attach(1);
		chk({o1, mp, hc}, {8'h1c, 8'h64, 8'h64});
		chk(mem.starts, s0);
		finish_test;
	end
endmodule : hcl_loader_bench
